/* logic/cda_device.sv */
// Sensor end: measurement sequencer and conversion-done / alert indicator
//
// Overview of operation
// - indicator is done flag or threshold alert
// - done flag goes high when result ready
// - alert level from compare against thresholds
// - sleep mode single-shot, cyclic mode periodic
// - sleep mode updates only at commanded completion
// - indicator cleared at start, set at end
// - host waits about 5 ms before sampling
// - single-shot rate no faster than 200 SPS
// - cyclic interval 125 to 4000 ms selectable
// - indicator held through each sleep interval
// - host sends cyclic command after power-up
// - power loss stops cycling; host resends command
// - cyclic mode runs without further commands
// - latest result returned at once on request
// - thresholds evaluated only at measurement instants
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cda_device
    import cda_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int MIN_CYCLES = MIN_PERIOD_CYC,
    parameter int BASE_CYCLES = BASE_INTERVAL_CYC
) (
    // Link to the host, clocks this whole end
    cda_link_if.dev link,
    // Power-on reset, synchronous to the link clock
    input wire logic srst_in,
    // Analog front end sample, asynchronous to the link
    input wire logic [DATA_W-1:0] sensor_value_in,
    // Status seen by the surrounding chip
    output logic cyclic_out,
    output logic busy_out
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CDA_ST_IDLE = 2'h0,
        CDA_ST_CONVERT = 2'h1,
        CDA_ST_SLEEP = 2'h3
    } cda_dev_state_t;

    cda_dev_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] gap_reg;
    logic [CNT_W-1:0] interval_cyc;
    logic [DATA_W-1:0] sample_meta_reg;
    logic [DATA_W-1:0] sample_reg;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] thr_lo_reg;
    logic [DATA_W-1:0] thr_hi_reg;
    logic [2:0] sel_reg;
    logic [2:0] sel_eff;
    logic [1:0] mode_reg;
    logic alert_fn_reg;
    logic cyclic_reg;
    logic indicator_reg;
    logic rate_ok;
    logic measure_cmd;
    logic cyclic_cmd;
    logic sleep_cmd;
    logic conv_start;
    logic conv_end;
    logic interval_end;
    logic cmp_hit;

    // ----------------------------------------------------------------
    // Command decode and timing terms
    // ----------------------------------------------------------------
    assign measure_cmd = link.cmd_valid && (link.cmd_code == CDA_CMD_MEASURE);
    assign cyclic_cmd = link.cmd_valid && (link.cmd_code == CDA_CMD_CYCLIC);
    assign sleep_cmd = link.cmd_valid && (link.cmd_code == CDA_CMD_SLEEP);

    // Guard against single shots closer than the least period
    assign rate_ok = (gap_reg >= CNT_W'(MIN_CYCLES - 1));

    // Selections above the top code clamp to the longest interval
    assign sel_eff = (sel_reg > INTERVAL_SEL_MAX) ? INTERVAL_SEL_MAX : sel_reg;
    assign interval_cyc = CNT_W'(BASE_CYCLES) << sel_eff;

    assign conv_end = (state_reg == CDA_ST_CONVERT)
        && (cnt_reg == CNT_W'(CONV_CYCLES - 1));
    assign interval_end = (state_reg == CDA_ST_SLEEP) && cyclic_reg
        && (cnt_reg >= interval_cyc - CNT_W'(1)); // A shorter sel mid-sleep ends it at once if cnt_reg is already past the new interval

    // A start comes from a command only in idle, else from the timer
    assign conv_start = ((state_reg == CDA_ST_IDLE)
        && ((measure_cmd && !cyclic_reg && rate_ok) || cyclic_cmd))
        || interval_end;

    // ----------------------------------------------------------------
    // Sample synchroniser
    // ----------------------------------------------------------------
    // The front end settles long before a conversion ends, so a plain
    // two-stage capture of the word is enough here.
    always_ff @(posedge link.link_clk) begin
        sample_meta_reg <= sensor_value_in;
        sample_reg <= sample_meta_reg;
    end

    // ----------------------------------------------------------------
    // Configuration from the link
    // ----------------------------------------------------------------
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            alert_fn_reg <= CFG_RESET[CFG_ALERT_BIT];
            sel_reg <= CFG_RESET[CFG_SEL_LSB +: 3];
            mode_reg <= CFG_RESET[CFG_MODE_LSB +: 2];
            thr_lo_reg <= THR_LO_RESET;
            thr_hi_reg <= THR_HI_RESET;
        end else if (link.cmd_valid) begin
            case (link.cmd_code)
                CDA_CMD_CONFIG: begin
                    alert_fn_reg <= link.cmd_data[CFG_ALERT_BIT];
                    sel_reg <= link.cmd_data[CFG_SEL_LSB +: 3];
                    mode_reg <= link.cmd_data[CFG_MODE_LSB +: 2];
                end
                CDA_CMD_THR_LO: thr_lo_reg <= link.cmd_data;
                CDA_CMD_THR_HI: thr_hi_reg <= link.cmd_data;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    // Reset stands for a power cycle: periodic operation is lost and
    // the host has to send the cyclic command again.
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            cyclic_reg <= 1'b0;
        end else if (cyclic_cmd) begin
            cyclic_reg <= 1'b1;
        end else if (sleep_cmd) begin
            cyclic_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            state_reg <= CDA_ST_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                CDA_ST_IDLE: begin
                    cnt_reg <= '0;
                    if (conv_start) begin
                        state_reg <= CDA_ST_CONVERT;
                    end
                end
                CDA_ST_CONVERT: begin
                    if (conv_end) begin
                        cnt_reg <= '0;
                        state_reg <= cyclic_reg ? CDA_ST_SLEEP : CDA_ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                CDA_ST_SLEEP: begin
                    if (!cyclic_reg) begin
                        cnt_reg <= '0;
                        state_reg <= CDA_ST_IDLE;
                    end else if (interval_end) begin
                        cnt_reg <= '0;
                        state_reg <= CDA_ST_CONVERT;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                default: begin
                    cnt_reg <= '0;
                    state_reg <= CDA_ST_IDLE;
                end
            endcase
        end
    end

    // Cycles since the last start, saturating once the period is met
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            gap_reg <= CNT_W'(MIN_CYCLES);
        end else if (conv_start) begin
            gap_reg <= '0;
        end else if (!rate_ok) begin
            gap_reg <= gap_reg + CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Threshold comparator
    // ----------------------------------------------------------------
    // Only the sample at the end of a conversion is judged, so short
    // excursions between measurements are invisible by design.
    always_comb begin
        case (mode_reg)
            CDA_CMP_ABOVE: cmp_hit = sample_reg > thr_hi_reg;
            CDA_CMP_BELOW: cmp_hit = sample_reg < thr_lo_reg;
            CDA_CMP_INSIDE: cmp_hit = (sample_reg >= thr_lo_reg)
                && (sample_reg <= thr_hi_reg);
            CDA_CMP_OUTSIDE: cmp_hit = (sample_reg < thr_lo_reg)
                || (sample_reg > thr_hi_reg);
            default: cmp_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Indicator and result
    // ----------------------------------------------------------------
    // Nothing touches the pin between an end and the next start, so it holds its
    // level through every sleep interval and between single shots.
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            indicator_reg <= 1'b0;
        end else if (conv_start) begin
            indicator_reg <= 1'b0;
        end else if (conv_end) begin
            indicator_reg <= alert_fn_reg ? cmp_hit : 1'b1;
        end
    end

    // Result is latched at the end of each conversion
    always_ff @(posedge link.link_clk) begin
        if (srst_in) begin
            result_reg <= '0;
        end else if (conv_end) begin
            result_reg <= sample_reg;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.indicator = indicator_reg;
    assign link.result = result_reg;
    assign link.alive = !srst_in; // Low while power is off, so the host sees it return
    assign cyclic_out = cyclic_reg;
    assign busy_out = (state_reg == CDA_ST_CONVERT);

endmodule
`default_nettype wire

/* shared/cda_pkg.sv */
// Shared constants for the conversion-done / alert indicator link
package cda_pkg;

    // ----------------------------------------------------------------
    // Clocks and link timing
    // ----------------------------------------------------------------
    localparam int CLOCK_HZ = 20000000;
    localparam int LINK_DIV = 4;
    localparam int LINK_HZ = CLOCK_HZ / LINK_DIV;
    localparam int CNT_W = 26;

    // Fastest single-shot rate and derived least period in link cycles
    localparam int MAX_SPS = 200;
    localparam int MIN_PERIOD_US = 1000000 / MAX_SPS;
    localparam int MIN_PERIOD_CYC = (LINK_HZ / 1000000) * MIN_PERIOD_US;

    // Conversion time of one measurement, kept inside the least period
    localparam int CONV_US = 4000;
    localparam int CONV_CYC = (LINK_HZ / 1000000) * CONV_US;

    // Shortest cyclic sleep interval; the others are doublings of it
    localparam int BASE_INTERVAL_MS = 125;
    localparam int BASE_INTERVAL_CYC = (LINK_HZ / 1000) * BASE_INTERVAL_MS;
    localparam logic [2:0] INTERVAL_SEL_MAX = 3'h5;

    // Host wait between a measure command and sampling the pin
    localparam int SAMPLE_WAIT_MS = 5;
    localparam int SAMPLE_WAIT_CYC = (CLOCK_HZ / 1000) * SAMPLE_WAIT_MS;

    // ----------------------------------------------------------------
    // Link commands
    // ----------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int CMD_N = 6;
    typedef enum logic [2:0] {
        CDA_CMD_MEASURE = 3'h0,
        CDA_CMD_CYCLIC = 3'h1,
        CDA_CMD_SLEEP = 3'h2,
        CDA_CMD_CONFIG = 3'h3,
        CDA_CMD_THR_LO = 3'h4,
        CDA_CMD_THR_HI = 3'h5
    } cda_cmd_t;

    // Config word fields
    localparam int CFG_ALERT_BIT = 0;
    localparam int CFG_SEL_LSB = 1;
    localparam int CFG_MODE_LSB = 4;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Comparison modes of the alert function
    typedef enum logic [1:0] {
        CDA_CMP_ABOVE = 2'h0,
        CDA_CMP_BELOW = 2'h1,
        CDA_CMP_INSIDE = 2'h2,
        CDA_CMP_OUTSIDE = 2'h3
    } cda_cmp_t;
    localparam logic [15:0] THR_LO_RESET = 16'h0000;
    localparam logic [15:0] THR_HI_RESET = 16'hffff;

    // ----------------------------------------------------------------
    // Host register map (word index on the host port)
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_THR_LO = 4'h2;
    localparam logic [3:0] REG_THR_HI = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h5;
    localparam int CTRL_MEASURE_BIT = 0;
    localparam int CTRL_CYCLIC_BIT = 1;
    localparam int CTRL_SLEEP_BIT = 2;

endpackage

/* shared/cda_link_if.sv */
// Link between the host controller and the sensor indicator logic
`timescale 1ns/1ns
`default_nettype none
interface cda_link_if;
    import cda_pkg::*;
    logic link_clk;
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic [DATA_W-1:0] cmd_data;
    logic [DATA_W-1:0] result;
    logic indicator;
    logic alive;

    modport dev (
        input link_clk, cmd_valid, cmd_code, cmd_data,
        output result, indicator, alive
    );
    modport host (
        output link_clk, cmd_valid, cmd_code, cmd_data,
        input result, indicator, alive
    );
endinterface
`default_nettype wire

/* logic/cda_host.sv */
// Host end: register port, link clock divider and command sender
`timescale 1ns/1ns
`default_nettype none
module cda_host
    import cda_pkg::*;
#(
    parameter int WAIT_CYCLES = SAMPLE_WAIT_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Software register port
    input wire logic [3:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    // Link to the sensor
    cda_link_if.host link
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] div_reg;
    logic link_clk_reg;
    logic slot;
    logic [CMD_N-1:0] pend_reg;
    logic [CMD_N-1:0] pend_set;
    logic [CMD_N-1:0] pend_clr;
    logic [2:0] pick;
    logic want_cyc_reg;
    logic cmd_valid_reg;
    logic [2:0] cmd_code_reg;
    logic [DATA_W-1:0] cmd_data_reg;
    logic [DATA_W-1:0] cfg_reg;
    logic [DATA_W-1:0] lo_reg;
    logic [DATA_W-1:0] hi_reg;
    logic [DATA_W-1:0] result_reg;
    logic ind_meta_reg;
    logic ind_sync_reg;
    logic alive_meta_reg;
    logic alive_sync_reg;
    logic alive_seen_reg;
    logic [CNT_W-1:0] wait_reg;
    logic waiting_reg;
    logic ind_sampled_reg;

    // ----------------------------------------------------------------
    // Link clock divider
    // ----------------------------------------------------------------
    // Commands change and results are taken on the edge that drives
    // the link clock low, half a link period from the sensor's edge.
    assign slot = (div_reg == 8'(LINK_DIV - 1));
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            div_reg <= '0;
            link_clk_reg <= 1'b0;
        end else begin
            div_reg <= slot ? 8'h00 : div_reg + 8'h01;
            link_clk_reg <= !slot && (div_reg + 8'h01 >= 8'(LINK_DIV / 2));
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        ind_meta_reg <= link.indicator;
        ind_sync_reg <= ind_meta_reg;
        alive_meta_reg <= link.alive;
        alive_sync_reg <= alive_meta_reg;
    end

    // ----------------------------------------------------------------
    // Software registers and pending commands
    // ----------------------------------------------------------------
    always_comb begin
        pend_set = '0;
        if (wr_in && addr_in == REG_CTRL) begin
            pend_set[CDA_CMD_MEASURE] = wdata_in[CTRL_MEASURE_BIT];
            pend_set[CDA_CMD_CYCLIC] = wdata_in[CTRL_CYCLIC_BIT];
            pend_set[CDA_CMD_SLEEP] = wdata_in[CTRL_SLEEP_BIT];
        end
        pend_set[CDA_CMD_CONFIG] = wr_in && addr_in == REG_CONFIG;
        pend_set[CDA_CMD_THR_LO] = wr_in && addr_in == REG_THR_LO;
        pend_set[CDA_CMD_THR_HI] = wr_in && addr_in == REG_THR_HI;
        // Sensor came up again while cycling was wanted: restart it
        if (alive_sync_reg && !alive_seen_reg && want_cyc_reg) begin
            pend_set[CDA_CMD_CYCLIC] = 1'b1;
        end
    end

    // Lowest pending command goes first
    always_comb begin
        pick = 3'h0;
        for (int i = CMD_N - 1; i >= 0; i--) begin
            if (pend_reg[i]) begin
                pick = 3'(i);
            end
        end
    end
    assign pend_clr = (slot && |pend_reg) ? (CMD_N'(1) << pick) : '0;

    // A request written in the cycle it is sent stays pending
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~pend_clr) | pend_set;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cfg_reg <= CFG_RESET;
            lo_reg <= THR_LO_RESET;
            hi_reg <= THR_HI_RESET;
            want_cyc_reg <= 1'b0;
            alive_seen_reg <= 1'b0;
        end else begin
            alive_seen_reg <= alive_sync_reg;
            if (pend_set[CDA_CMD_CYCLIC]) begin
                want_cyc_reg <= 1'b1;
            end else if (pend_set[CDA_CMD_SLEEP]) begin
                want_cyc_reg <= 1'b0;
            end
            if (pend_set[CDA_CMD_CONFIG]) begin
                cfg_reg <= wdata_in;
            end
            if (pend_set[CDA_CMD_THR_LO]) begin
                lo_reg <= wdata_in;
            end
            if (pend_set[CDA_CMD_THR_HI]) begin
                hi_reg <= wdata_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command sender and result capture, one link cycle per command
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg <= 3'h0;
            cmd_data_reg <= '0;
            result_reg <= '0;
        end else if (slot) begin
            result_reg <= link.result;
            cmd_valid_reg <= |pend_reg;
            cmd_code_reg <= pick;
            case (pick)
                CDA_CMD_CONFIG: cmd_data_reg <= cfg_reg;
                CDA_CMD_THR_LO: cmd_data_reg <= lo_reg;
                CDA_CMD_THR_HI: cmd_data_reg <= hi_reg;
                default: cmd_data_reg <= '0;
            endcase
        end
    end

    // Pin is judged only after the settle wait following a measure
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wait_reg <= '0;
            waiting_reg <= 1'b0;
            ind_sampled_reg <= 1'b0;
        end else if (slot && |pend_reg && pick == CDA_CMD_MEASURE) begin
            wait_reg <= CNT_W'(WAIT_CYCLES - 1);
            waiting_reg <= 1'b1;
        end else if (waiting_reg) begin
            if (wait_reg == '0) begin
                waiting_reg <= 1'b0;
                ind_sampled_reg <= ind_sync_reg;
            end else begin
                wait_reg <= wait_reg - CNT_W'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                REG_CTRL: rdata_out <= {15'h0000, want_cyc_reg};
                REG_CONFIG: rdata_out <= cfg_reg;
                REG_THR_LO: rdata_out <= lo_reg;
                REG_THR_HI: rdata_out <= hi_reg;
                REG_STATUS: rdata_out <= {11'h000, |pend_reg, alive_sync_reg,
                    waiting_reg, ind_sampled_reg, ind_sync_reg};
                REG_RESULT: rdata_out <= result_reg;
                default: rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Link outputs
    // ----------------------------------------------------------------
    assign link.link_clk = link_clk_reg;
    assign link.cmd_valid = cmd_valid_reg;
    assign link.cmd_code = cmd_code_reg;
    assign link.cmd_data = cmd_data_reg;

endmodule
`default_nettype wire

/* bench/cda_link_checker.sv */
// Assertions on the indicator link between host and sensor ends
`timescale 1ns/1ns
`default_nettype none
module cda_link_checker
    import cda_pkg::*;
(
    // Link signals and device reset
    input wire logic link_clk,
    input wire logic srst_in,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [DATA_W-1:0] result,
    input wire logic indicator,
    input wire logic alive
);
    logic [7:0] gap_reg;
    logic [7:0] rgap_reg;
    default clocking @(posedge link_clk); endclocking
    default disable iff (srst_in);
    // A conversion keeps the pin low for at least six cycles after it falls
    sequence conv_low;
        !indicator [*6];
    endsequence
    // Cycles since the last start; saturates so long idle never wraps
    always_ff @(posedge link_clk) begin
        if (srst_in || $fell(indicator))
            gap_reg <= srst_in ? 8'hff : 8'h00;
        else if (gap_reg != 8'hff)
            gap_reg <= gap_reg + 8'h01;
    end
    // Cycles since the result word last changed
    always_ff @(posedge link_clk) begin
        if (srst_in || $changed(result))
            rgap_reg <= srst_in ? 8'hff : 8'h00;
        else if (rgap_reg != 8'hff)
            rgap_reg <= rgap_reg + 8'h01;
    end
    reset_clear_a: assert property ($fell(srst_in) |-> !indicator && result == '0)
        else $error("pin or result not clear after reset");
    alive_high_a: assert property (!$past(srst_in) |-> alive)
        else $error("alive low while powered");
    code_legal_a: assert property (cmd_valid |-> cmd_code <= 3'h5)
        else $error("illegal command code");
    low_run_a: assert property ($fell(indicator) |=> conv_low)
        else $error("pin set before conversion end");
    rise_late_a: assert property ($rose(indicator) |-> !$past(indicator, 6))
        else $error("pin rose without a conversion");
    result_end_a: assert property ($changed(result) |-> !$past(indicator))
        else $error("result changed outside a conversion end");
    start_gap_a: assert property ($fell(indicator) |-> gap_reg >= 8'd10)
        else $error("starts too close together");
    result_gap_a: assert property ($changed(result) |-> rgap_reg >= 8'd10)
        else $error("results too close together");
endmodule
`default_nettype wire

/* bench/tb_conversion_done_alert_pin.sv */
// Self-checking bench: host register port drives both link ends
`timescale 1ns/1ns
`default_nettype none
module tb_conversion_done_alert_pin;
    import cda_pkg::*;
    logic clock_in = 1'b0, srst_in = 1'b1, dev_srst = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic cyclic, busy;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, sensor = 16'h0000, cfg = 16'h0000;
    logic [15:0] rdata_out, got, lo, hi;
    int fail_count = 0, compares = 0, seed = 33544, n;
    cda_link_if link ();
    always #25 clock_in = ~clock_in;
    cda_host #(.WAIT_CYCLES(60)) i_cda_host (.clock_in(clock_in), .srst_in(srst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .link(link.host));
    cda_device #(.CONV_CYCLES(8), .MIN_CYCLES(12), .BASE_CYCLES(4)) i_cda_device (
        .link(link.dev), .srst_in(dev_srst), .sensor_value_in(sensor),
        .cyclic_out(cyclic), .busy_out(busy));
    cda_link_checker i_cda_link_checker (.link_clk(link.link_clk), .srst_in(dev_srst),
        .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .result(link.result),
        .indicator(link.indicator), .alive(link.alive));
    // Reference pin level for the current function and thresholds
    function automatic logic model(input logic [15:0] v);
        if (cfg[CFG_ALERT_BIT] == 1'b0)
            return 1'b1;
        case (cfg[CFG_MODE_LSB +: 2])
            CDA_CMP_ABOVE: return v > hi;
            CDA_CMP_BELOW: return v < lo;
            CDA_CMP_INSIDE: return v >= lo && v <= hi;
            default: return v < lo || v > hi;
        endcase
    endfunction
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Register port cycles; read data is taken in the cycle after the strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask
    // Waits for a pin level on the falling edge, where it is settled
    task automatic edge_wait(input logic lvl);
        int k = 0;
        while (link.indicator !== lvl && k < 3000) begin
            @(negedge clock_in);
            k++;
        end
        n += k;
        if (k >= 3000) begin
            fail_count++;
            close_out();
        end
    endtask
    // Spacing keeps every command outside the least single-shot period
    task automatic measure(input logic [15:0] v);
        sensor <= v;
        repeat (30) @(posedge clock_in);
        wr(REG_CTRL, 16'h0001);
        n = 0;
        do begin
            rd(REG_STATUS);
            n++;
        end while ((got[2] | got[4]) !== 1'b0 && n < 300);
        if (n >= 300) begin
            fail_count++;
            close_out();
        end
        chk(16'(got[1]), 16'(model(v)));
        rd(REG_RESULT);
        chk(got, v);
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        dev_srst <= 1'b0;
        rd(REG_RESULT);
        chk(got, 16'h0000);
        rd(4'hf);
        chk(got, 16'h0000);
        chk(16'(cyclic), 16'h0000);
        measure(16'($random(seed)));
        // Every compare mode, with a random value and one on the upper threshold
        for (int m = 0; m < 4; m++) begin
            lo = 16'($random(seed));
            hi = 16'($random(seed));
            cfg = 16'h0001 | 16'(m << CFG_MODE_LSB);
            wr(REG_CONFIG, cfg);
            wr(REG_THR_LO, lo);
            wr(REG_THR_HI, hi);
            rd(REG_CONFIG);
            chk(got, cfg);
            measure(16'($random(seed)));
            measure(hi);
        end
        // Cyclic run through every interval with no further measure command
        cfg = 16'h0000;
        wr(REG_CONFIG, cfg);
        wr(REG_CTRL, 16'h0002);
        for (int s = 0; s < 6; s++) begin
            sensor <= 16'($random(seed));
            wr(REG_CONFIG, 16'(s << CFG_SEL_LSB));
            edge_wait(1'b1);
            edge_wait(1'b0);
            edge_wait(1'b1);
            n = 0;
            edge_wait(1'b0);
            chk(16'(n >= (16 << s) - 4 && n <= (16 << s) + 12), 16'h0001);
            chk(16'(busy), 16'h0001);
            rd(REG_RESULT);
            chk(got, sensor);
        end
        // Power loss: cycling stops and the host restarts it unprompted
        dev_srst <= 1'b1;
        repeat (12) @(posedge clock_in);
        chk(16'(cyclic), 16'h0000);
        dev_srst <= 1'b0;
        edge_wait(1'b1);
        chk(16'(cyclic), 16'h0001);
        wr(REG_CTRL, 16'h0004);
        repeat (100) @(posedge clock_in);
        chk(16'(cyclic), 16'h0000);
        measure(16'($random(seed)));
        n = 0;
        repeat (200) begin
            @(negedge clock_in);
            if (link.indicator !== 1'b1)
                n++;
        end
        chk(16'(n), 16'h0000);
        close_out();
    end
endmodule
`default_nettype wire
